// ===== bench/sms_ctrl_model.sv
`timescale 1ns/1ps
// Motion controller stand-in: issues commands and drive feedback
module sms_ctrl_model #(
    parameter int unsigned PERIOD = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [31:0] i_target,
    input wire logic [31:0] i_act,
    input wire logic i_servo_on,
    input wire logic i_used,
    input wire logic i_zsp,
    input wire logic i_mend,
    output sms_pkg::sms_fb_t o_fb
);
    import sms_pkg::*;
    logic [7:0] cnt;
    logic [31:0] cmd;

    ////////////////////////////////////////////////////////////////
    // Absolute command taken once per sync period
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cnt <= 8'h00;
            cmd <= i_target;
        end else if (cnt == 8'(PERIOD - 1)) begin
            cnt <= 8'h00;
            cmd <= i_target;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Feedback bundle toward the drive
    always_comb begin
        o_fb = '0;
        o_fb.cmd_pos = cmd;
        o_fb.act_pos = i_act;
        o_fb.speed_cmd = 32'h0000_0123;
        o_fb.torque_act = 16'h0064;
        o_fb.status_base = 16'h0637;
        o_fb.status_do2[DO2_ZSP_BIT] = i_zsp;
        o_fb.status_do5[DO5_MEND_BIT] = i_mend;
        o_fb.servo_on = i_servo_on;
        o_fb.target_used = i_used;
    end
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ps
// Self-checking bench for mode switching and status
module testbench;
    import sms_pkg::*;
    typedef struct {
        logic wr;
        logic [IW-1:0] idx;
        logic [31:0] wd;
        logic [31:0] rd;
        logic err;
    } sms_row_t;
    logic clk, rst_n, son, used, zsp, mend, err;
    logic [31:0] target, act, rd;
    logic [7:0] disp;
    logic [15:0] stat;
    sms_apb_req_t req;
    sms_apb_rsp_t rsp;
    sms_fb_t fb;
    sms_cfg_t cfg;
    int miscompares, checks;
    sms_row_t rows[25];
    logic [7:0] codes[8];

    sms_mode_status #(.TICK_CYCLES(10)) dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_apb(req),
        .o_apb(rsp), .i_fb(fb), .o_cfg(cfg), .o_mode_display(disp), .o_status_word(stat));
    sms_ctrl_model #(.PERIOD(8)) peer (.i_ref_clk(clk), .i_rst_n(rst_n), .i_target(target),
        .i_act(act), .i_servo_on(son), .i_used(used), .i_zsp(zsp), .i_mend(mend), .o_fb(fb));

    ////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////
    // Verdict, comparison and timeout helpers
    task automatic close_out;
        if (miscompares == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask

    task automatic hang(input string name);
        miscompares++;
        $display("BAD %s exp done seen timeout", name);
        close_out();
    endtask

    function automatic logic [15:0] pick(input int sel);
        return sel != 0 ? {15'h0000, stat[SW_FERR_BIT]} : {8'h00, disp};
    endfunction

    // Wait, bounded, for the display or the error bit
    task automatic wait_for(input int sel, input logic [15:0] exp, input int n);
        int k;
        k = 0;
        while (pick(sel) !== exp && k < n) begin
            @(posedge clk);
            k++;
        end
        if (pick(sel) !== exp)
            hang(sel != 0 ? "following_error" : "mode_display");
        else
            chk("watched", 32'(pick(sel)), 32'(exp));
    endtask

    // One APB transfer: setup, access, hold until pready
    task automatic apb(input logic wr, input logic [IW-1:0] idx, input logic [31:0] wd);
        int n;
        @(posedge clk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= {idx, 2'b00};
        req.pwdata <= wd;
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (rsp.pready !== 1'b1) begin
            hang("pready");
        end else begin
            rd = rsp.prdata;
            err = rsp.pslverr;
            req.psel <= 1'b0;
            req.penable <= 1'b0;
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        hang("run");
    end

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst_n = 1'b0;
        req = '0;
        target = 32'h0000_03e8;
        act = 32'h0000_03e8;
        {son, used, zsp, mend} = 4'h0;
        miscompares = 0;
        checks = 0;
        rows = '{'{1'b0, IDX_CTRL, 32'h0, 32'h0, 1'b0},
            '{1'b0, IDX_TRQ_POS, 32'h0, 32'h3e8, 1'b0}, '{1'b1, IDX_TRQ_NEG, 32'h1f4, 32'h0, 1'b0},
            '{1'b0, IDX_TRQ_NEG, 32'h0, 32'h1f4, 1'b0}, '{1'b0, IDX_TRQ_POS, 32'h0, 32'h3e8, 1'b0},
            '{1'b0, IDX_RANGE_MIN, 32'h0, 32'h8000_0000, 1'b0},
            '{1'b0, IDX_RANGE_MAX, 32'h0, 32'h7fff_ffff, 1'b0},
            '{1'b1, IDX_SW_MIN, 32'hffff_fc18, 32'h0, 1'b0},
            '{1'b0, IDX_SW_MIN, 32'h0, 32'hffff_fc18, 1'b0},
            '{1'b0, IDX_SW_MAX, 32'h0, 32'h7fff_ffff, 1'b0},
            '{1'b0, IDX_GEAR_NUM, 32'h0, 32'h1, 1'b0}, '{1'b1, IDX_GEAR_DEN, 32'h3, 32'h0, 1'b0},
            '{1'b0, IDX_GEAR_DEN, 32'h0, 32'h3, 1'b0}, '{1'b0, IDX_TRQ_ACT, 32'h0, 32'h64, 1'b0},
            '{1'b0, IDX_DEMAND, 32'h0, 32'h3e8, 1'b0}, '{1'b0, IDX_EFFORT, 32'h0, 32'h123, 1'b0},
            '{1'b0, IDX_DROOP, 32'h0, 32'h0, 1'b0}, '{1'b1, IDX_STAT, 32'hffff, 32'h0, 1'b1},
            '{1'b1, IDX_DROOP, 32'h5, 32'h0, 1'b1}, '{1'b0, 18'h00010, 32'h0, 32'h0, 1'b1},
            '{1'b0, IDX_MODE_DISP, 32'h0, 32'h8, 1'b0}, '{1'b1, IDX_MODE_REQ, 32'h2, 32'h0, 1'b1},
            '{1'b1, IDX_FE_WIN, 32'h5, 32'h0, 1'b0}, '{1'b1, IDX_FE_TMO, 32'h2, 32'h0, 1'b0},
            '{1'b0, IDX_FE_TMO, 32'h0, 32'h2, 1'b0}};
        codes = '{MODE_CSV, MODE_CST, MODE_PP, MODE_PV, MODE_TQ, MODE_CT, MODE_CSP, MODE_PT};
        repeat (6) @(posedge clk);
        chk("mode_display", 32'(disp), 32'(MODE_CSP));
        chk("status_word", 32'(stat), 32'h0);
        rst_n <= 1'b1;
        // Register table rows
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].idx, rows[i].wd);
            chk("prdata", rd, rows[i].rd);
            chk("pslverr", 32'(err), 32'(rows[i].err));
        end
        chk("cfg_fe_window", cfg.fe_window, 32'h0000_0005);
        chk("cfg_trq_neg", 32'(cfg.trq_neg_lim), 32'h0000_01f4);
        // Every mode code except homing and jog, servo off throughout
        foreach (codes[i]) begin
            apb(1'b1, IDX_MODE_REQ, 32'(codes[i]));
            wait_for(0, 16'(codes[i]), 8);
        end
        // Gated switch from point table to homing
        apb(1'b1, IDX_CTRL, 32'h0);
        apb(1'b1, IDX_MODE_REQ, 32'(MODE_HM));
        repeat (8) @(posedge clk);
        chk("mode_display", 32'(disp), 32'(MODE_PT));
        apb(1'b1, IDX_CTRL, 32'h038f);
        apb(1'b0, IDX_CTRL, 32'h0);
        chk("control_word", rd, 32'h008f);
        chk("cfg_ctrl", 32'(cfg.ctrl_word), 32'h0000_008f);
        son <= 1'b1;
        zsp <= 1'b1;
        repeat (8) @(posedge clk);
        chk("mode_display", 32'(disp), 32'(MODE_PT));
        mend <= 1'b1;
        wait_for(0, 16'(MODE_HM), 6);
        apb(1'b1, IDX_CTRL, 32'h0370);
        apb(1'b0, IDX_CTRL, 32'h0);
        chk("control_word", rd, 32'h0370);
        son <= 1'b0;
        mend <= 1'b0;
        apb(1'b1, IDX_MODE_REQ, 32'(MODE_JG));
        wait_for(0, 16'(MODE_JG), 6);
        apb(1'b1, IDX_CTRL, 32'h0);
        apb(1'b1, IDX_MODE_REQ, 32'(MODE_CSP));
        wait_for(0, 16'(MODE_CSP), 6);
        // Command-followed bit and reserved bit in position mode
        son <= 1'b1;
        used <= 1'b1;
        repeat (4) @(posedge clk);
        chk("status_word", 32'(stat), 32'h1237);
        used <= 1'b0;
        repeat (4) @(posedge clk);
        chk("status_word", 32'(stat), 32'h0237);
        // Following error over window 5 for 2 ticks
        act <= 32'h0000_03de;
        repeat (4) @(posedge clk);
        chk("status_word", 32'(stat), 32'h0237);
        apb(1'b0, IDX_DROOP, 32'h0);
        chk("droop", rd, 32'h0000_000a);
        wait_for(1, 16'h0001, 60);
        act <= 32'h0000_03e8;
        wait_for(1, 16'h0000, 10);
        // Reset in mid-run returns to position mode
        son <= 1'b0;
        apb(1'b1, IDX_MODE_REQ, 32'(MODE_PP));
        wait_for(0, 16'(MODE_PP), 6);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk("mode_display", 32'(disp), 32'(MODE_CSP));
        chk("status_word", 32'(stat), 32'h0);
        rst_n <= 1'b1;
        apb(1'b0, IDX_MODE_REQ, 32'h0);
        chk("mode_request", rd, 32'(MODE_CSP));
        apb(1'b0, IDX_TRQ_NEG, 32'h0);
        chk("trq_neg_lim", rd, 32'(TRQ_LIM_RST));
        chk("cfg_gear_den", cfg.gear_den, GEAR_RST);
        close_out();
    end
endmodule

// ===== rtl/sms_ferr_timer.sv
`timescale 1ns/1ps
module sms_ferr_timer (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_tick,
    input wire logic i_over,
    input wire logic [15:0] i_timeout,
    output logic o_flag
);
    logic [15:0] count;
    logic [15:0] next_count;
    logic next_flag;

    // Count ms ticks while droop is over the window
    always_comb begin
        next_count = count;
        if (!i_over) begin
            next_count = 16'h0000;
        end else if (i_tick && count != 16'hffff) begin
            next_count = count + 16'h0001;
        end
        next_flag = i_over && (count >= i_timeout);
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            count <= 16'h0000;
            o_flag <= 1'b0;
        end else begin
            count <= next_count;
            o_flag <= next_flag;
        end
    end

    // Flag drops one cycle after droop returns inside the window
    a_ferr_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !i_over |=> !o_flag) else $error("following error flag held");
endmodule

// ===== rtl/sms_mode_status.sv
`timescale 1ns/1ps
module sms_mode_status #(
    parameter int unsigned TICK_CYCLES = sms_pkg::FE_TICK_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input sms_pkg::sms_apb_req_t i_apb,
    output sms_pkg::sms_apb_rsp_t o_apb,
    input sms_pkg::sms_fb_t i_fb,
    output sms_pkg::sms_cfg_t o_cfg,
    output logic [7:0] o_mode_display,
    output logic [15:0] o_status_word
);
    import sms_pkg::*;

    typedef enum logic [1:0] {
        SMS_IDLE = 2'b01,
        SMS_PENDING = 2'b10
    } sms_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    sms_state_t state;
    sms_state_t next_state;
    logic [7:0] mode_req;
    logic [7:0] next_mode_req;
    logic [7:0] next_mode_display;
    sms_cfg_t next_cfg;
    sms_apb_rsp_t next_apb;
    logic [31:0] droop;
    logic [31:0] next_droop;
    logic [31:0] demand;
    logic [31:0] effort;
    logic [15:0] torque_act;
    logic [15:0] next_status;
    logic [31:0] tick_cnt;
    logic [31:0] next_tick_cnt;
    logic tick;
    logic next_tick;
    logic fe_over;
    logic fe_flag;
    logic [31:0] droop_abs;
    logic [IW-1:0] idx;
    logic wr_en;
    logic req_valid;
    logic pos_gated;
    logic switch_ok;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic mode_supported(input logic [7:0] m);
        mode_supported = (m == MODE_CSP) || (m == MODE_CSV) || (m == MODE_CST) ||
            (m == MODE_PP) || (m == MODE_PV) || (m == MODE_TQ) || (m == MODE_HM) ||
            (m == MODE_CT) || (m == MODE_PT) || (m == MODE_JG);
    endfunction

    function automatic logic mode_positioning(input logic [7:0] m);
        mode_positioning = (m == MODE_PT) || (m == MODE_JG) || (m == MODE_HM);
    endfunction

    // Bus strobes and switch condition
    always_comb begin
        idx = i_apb.paddr[AW-1:2];
        wr_en = i_apb.psel && i_apb.penable && o_apb.pready && i_apb.pwrite;
        req_valid = mode_supported(i_apb.pwdata[7:0]);
        pos_gated = mode_positioning(o_mode_display) && mode_positioning(mode_req);
        if (i_fb.servo_on) begin
            switch_ok = i_fb.status_do2[DO2_ZSP_BIT] && i_fb.status_do5[DO5_MEND_BIT];
        end else begin
            switch_ok = i_fb.status_do2[DO2_ZSP_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode switching

    // Latch request, finish on first cycle the condition holds
    always_comb begin
        next_state = state;
        next_mode_req = mode_req;
        next_mode_display = o_mode_display;
        case (state)
            SMS_IDLE: begin
                if (wr_en && idx == IDX_MODE_REQ && req_valid) begin
                    next_mode_req = i_apb.pwdata[7:0];
                    next_state = SMS_PENDING;
                end
            end
            SMS_PENDING: begin
                if (wr_en && idx == IDX_MODE_REQ && req_valid) begin
                    next_mode_req = i_apb.pwdata[7:0];
                end else if (!pos_gated || switch_ok) begin
                    next_mode_display = mode_req;
                    next_state = SMS_IDLE;
                end
            end
            default: begin
                next_state = SMS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            state <= SMS_IDLE;
            mode_req <= MODE_CSP;
            o_mode_display <= MODE_CSP;
        end else begin
            state <= next_state;
            mode_req <= next_mode_req;
            o_mode_display <= next_mode_display;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    // Software writes; mode bits of control frozen while switching
    always_comb begin
        next_cfg = o_cfg;
        if (wr_en) begin
            case (idx)
                IDX_CTRL: begin
                    if (state == SMS_PENDING) begin
                        next_cfg.ctrl_word = (i_apb.pwdata[15:0] & ~CW_OMS_MASK) |
                            (o_cfg.ctrl_word & CW_OMS_MASK);
                    end else begin
                        next_cfg.ctrl_word = i_apb.pwdata[15:0];
                    end
                end
                IDX_FE_WIN: next_cfg.fe_window = i_apb.pwdata;
                IDX_FE_TMO: next_cfg.fe_timeout = i_apb.pwdata[15:0];
                IDX_TRQ_POS: next_cfg.trq_pos_lim = i_apb.pwdata[15:0];
                IDX_TRQ_NEG: next_cfg.trq_neg_lim = i_apb.pwdata[15:0];
                IDX_RANGE_MIN: next_cfg.range_min = i_apb.pwdata;
                IDX_RANGE_MAX: next_cfg.range_max = i_apb.pwdata;
                IDX_SW_MIN: next_cfg.sw_min = i_apb.pwdata;
                IDX_SW_MAX: next_cfg.sw_max = i_apb.pwdata;
                IDX_GEAR_NUM: next_cfg.gear_num = i_apb.pwdata;
                IDX_GEAR_DEN: next_cfg.gear_den = i_apb.pwdata;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_cfg.ctrl_word <= CTRL_RST;
            o_cfg.fe_window <= FE_WIN_RST;
            o_cfg.fe_timeout <= FE_TMO_RST;
            o_cfg.trq_pos_lim <= TRQ_LIM_RST;
            o_cfg.trq_neg_lim <= TRQ_LIM_RST;
            o_cfg.range_min <= POS_MIN_RST;
            o_cfg.range_max <= POS_MAX_RST;
            o_cfg.sw_min <= POS_MIN_RST;
            o_cfg.sw_max <= POS_MAX_RST;
            o_cfg.gear_num <= GEAR_RST;
            o_cfg.gear_den <= GEAR_RST;
        end else begin
            o_cfg <= next_cfg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Monitoring and status

    // Droop, millisecond tick and status word
    always_comb begin
        next_droop = i_fb.cmd_pos - i_fb.act_pos;
        droop_abs = droop[31] ? (32'h0000_0000 - droop) : droop;
        fe_over = droop_abs > o_cfg.fe_window;
        next_tick = (tick_cnt == 32'(TICK_CYCLES - 1));
        next_tick_cnt = next_tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
        next_status = i_fb.status_base;
        if (o_mode_display == MODE_CSP) begin
            next_status[SW_RSV_BIT] = 1'b0;
            next_status[SW_FOLLOW_BIT] = i_fb.servo_on && i_fb.target_used;
            next_status[SW_FERR_BIT] = fe_flag;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            droop <= 32'h0000_0000;
            demand <= 32'h0000_0000;
            effort <= 32'h0000_0000;
            torque_act <= 16'h0000;
            tick_cnt <= 32'h0000_0000;
            tick <= 1'b0;
            o_status_word <= 16'h0000;
        end else begin
            droop <= next_droop;
            demand <= i_fb.cmd_pos;
            effort <= i_fb.speed_cmd;
            torque_act <= i_fb.torque_act;
            tick_cnt <= next_tick_cnt;
            tick <= next_tick;
            o_status_word <= next_status;
        end
    end

    sms_ferr_timer u_ferr_timer (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_tick(tick),
        .i_over(fe_over),
        .i_timeout(o_cfg.fe_timeout),
        .o_flag(fe_flag)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait cycle, answer registered

    always_comb begin
        next_apb.pready = i_apb.psel && i_apb.penable && !o_apb.pready;
        next_apb.pslverr = 1'b0;
        next_apb.prdata = 32'h0000_0000;
        if (next_apb.pready) begin
            case (idx)
                IDX_CTRL: next_apb.prdata = {16'h0000, o_cfg.ctrl_word};
                IDX_STAT: next_apb.prdata = {16'h0000, o_status_word};
                IDX_MODE_REQ: next_apb.prdata = {24'h000000, mode_req};
                IDX_MODE_DISP: next_apb.prdata = {24'h000000, o_mode_display};
                IDX_DEMAND: next_apb.prdata = demand;
                IDX_FE_WIN: next_apb.prdata = o_cfg.fe_window;
                IDX_FE_TMO: next_apb.prdata = {16'h0000, o_cfg.fe_timeout};
                IDX_TRQ_ACT: next_apb.prdata = {16'h0000, torque_act};
                IDX_TRQ_POS: next_apb.prdata = {16'h0000, o_cfg.trq_pos_lim};
                IDX_TRQ_NEG: next_apb.prdata = {16'h0000, o_cfg.trq_neg_lim};
                IDX_RANGE_MIN: next_apb.prdata = o_cfg.range_min;
                IDX_RANGE_MAX: next_apb.prdata = o_cfg.range_max;
                IDX_SW_MIN: next_apb.prdata = o_cfg.sw_min;
                IDX_SW_MAX: next_apb.prdata = o_cfg.sw_max;
                IDX_GEAR_NUM: next_apb.prdata = o_cfg.gear_num;
                IDX_GEAR_DEN: next_apb.prdata = o_cfg.gear_den;
                IDX_DROOP: next_apb.prdata = droop;
                IDX_EFFORT: next_apb.prdata = effort;
                default: next_apb.pslverr = 1'b1;
            endcase
            if (i_apb.pwrite) begin
                next_apb.prdata = 32'h0000_0000;
                if (idx == IDX_STAT || idx == IDX_MODE_DISP || idx == IDX_DEMAND ||
                    idx == IDX_TRQ_ACT || idx == IDX_DROOP || idx == IDX_EFFORT) begin
                    next_apb.pslverr = 1'b1;
                end
                if (idx == IDX_MODE_REQ && !req_valid) begin
                    next_apb.pslverr = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_apb <= '0;
        end else begin
            o_apb <= next_apb;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    a_reset_mode_csp: assert property (@(posedge i_ref_clk)
        !i_rst_n |=> o_mode_display == MODE_CSP) else $error("mode not csp after reset");

    a_pos_switch_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (state == SMS_PENDING && pos_gated && !switch_ok) |=> $stable(o_mode_display))
        else $error("display changed with condition false");

    a_pos_switch_done: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (state == SMS_PENDING && !wr_en && (!pos_gated || switch_ok))
        |=> (o_mode_display == $past(mode_req)) && state == SMS_IDLE)
        else $error("switch did not complete");

    a_servo_off_zsp: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (state == SMS_PENDING && !wr_en && !i_fb.servo_on && i_fb.status_do2[DO2_ZSP_BIT])
        |=> state == SMS_IDLE) else $error("zero speed alone not accepted at servo off");

    a_mode_hold_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        state == SMS_IDLE |=> $stable(o_mode_display)) else $error("display moved while idle");

    a_bad_mode_drop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (wr_en && idx == IDX_MODE_REQ && !req_valid && state == SMS_IDLE)
        |=> state == SMS_IDLE && $stable(mode_req)) else $error("unsupported mode accepted");

    a_pending_latch: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (wr_en && idx == IDX_MODE_REQ && req_valid)
        |=> state == SMS_PENDING && mode_req == $past(i_apb.pwdata[7:0]))
        else $error("mode request not latched");

    a_oms_lock: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        state == SMS_PENDING |=> (o_cfg.ctrl_word & CW_OMS_MASK) ==
        ($past(o_cfg.ctrl_word) & CW_OMS_MASK)) else $error("mode bits changed mid switch");

    a_follow_bit: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (o_mode_display == MODE_CSP) |=> o_status_word[SW_FOLLOW_BIT] ==
        $past(i_fb.servo_on && i_fb.target_used)) else $error("follow bit wrong");

    a_droop_value: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        1'b1 |=> droop == $past(i_fb.cmd_pos - i_fb.act_pos))
        else $error("droop not command minus actual");

    a_demand_value: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        1'b1 |=> demand == $past(i_fb.cmd_pos)) else $error("demand not command position");

    a_effort_value: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        1'b1 |=> effort == $past(i_fb.speed_cmd)) else $error("effort not speed command");

    a_torque_value: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        1'b1 |=> torque_act == $past(i_fb.torque_act)) else $error("actual torque not held");

    a_ferr_status: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (o_mode_display == MODE_CSP) |=> o_status_word[SW_FERR_BIT] == $past(fe_flag))
        else $error("following error bit wrong");

    a_rsv_status: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (o_mode_display == MODE_CSP) |=> !o_status_word[SW_RSV_BIT])
        else $error("reserved status bit not zero");

    a_apb_wait: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_apb.psel && i_apb.penable && !o_apb.pready) |=> o_apb.pready ##1 !o_apb.pready)
        else $error("apb answer not one cycle late");
endmodule

// ===== rtl/sms_pkg.sv
package sms_pkg;

    // Clock and timing
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned FE_TICK_MS = 1;
    localparam int unsigned FE_TICK_CYCLES = CLK_HZ / 1000 * FE_TICK_MS;

    // APB widths; byte address is four times the register index
    localparam int unsigned AW = 20;
    localparam int unsigned IW = 18;

    // Register indices
    localparam logic [IW-1:0] IDX_CTRL = 18'h06040;
    localparam logic [IW-1:0] IDX_STAT = 18'h06041;
    localparam logic [IW-1:0] IDX_MODE_REQ = 18'h06060;
    localparam logic [IW-1:0] IDX_MODE_DISP = 18'h06061;
    localparam logic [IW-1:0] IDX_DEMAND = 18'h06062;
    localparam logic [IW-1:0] IDX_FE_WIN = 18'h06065;
    localparam logic [IW-1:0] IDX_FE_TMO = 18'h06066;
    localparam logic [IW-1:0] IDX_TRQ_ACT = 18'h06077;
    localparam logic [IW-1:0] IDX_RANGE_MIN = 18'h1607b;
    localparam logic [IW-1:0] IDX_RANGE_MAX = 18'h2607b;
    localparam logic [IW-1:0] IDX_SW_MIN = 18'h1607d;
    localparam logic [IW-1:0] IDX_SW_MAX = 18'h2607d;
    localparam logic [IW-1:0] IDX_GEAR_NUM = 18'h16091;
    localparam logic [IW-1:0] IDX_GEAR_DEN = 18'h26091;
    localparam logic [IW-1:0] IDX_TRQ_POS = 18'h060e0;
    localparam logic [IW-1:0] IDX_TRQ_NEG = 18'h060e1;
    localparam logic [IW-1:0] IDX_DROOP = 18'h060f4;
    localparam logic [IW-1:0] IDX_EFFORT = 18'h060fa;

    // Operating mode codes
    localparam logic [7:0] MODE_PP = 8'h01;
    localparam logic [7:0] MODE_PV = 8'h03;
    localparam logic [7:0] MODE_TQ = 8'h04;
    localparam logic [7:0] MODE_HM = 8'h06;
    localparam logic [7:0] MODE_CSP = 8'h08;
    localparam logic [7:0] MODE_CSV = 8'h09;
    localparam logic [7:0] MODE_CST = 8'h0a;
    localparam logic [7:0] MODE_CT = 8'hec;
    localparam logic [7:0] MODE_PT = 8'hff;
    localparam logic [7:0] MODE_JG = 8'hfe;

    // Field positions
    localparam logic [15:0] CW_OMS_MASK = 16'h0370;
    localparam int unsigned SW_RSV_BIT = 10;
    localparam int unsigned SW_FOLLOW_BIT = 12;
    localparam int unsigned SW_FERR_BIT = 13;
    localparam int unsigned DO2_ZSP_BIT = 3;
    localparam int unsigned DO5_MEND_BIT = 6;

    // Reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [31:0] FE_WIN_RST = 32'h0000_0000;
    localparam logic [15:0] FE_TMO_RST = 16'h0000;
    localparam logic [15:0] TRQ_LIM_RST = 16'h03e8;
    localparam logic [31:0] POS_MIN_RST = 32'h8000_0000;
    localparam logic [31:0] POS_MAX_RST = 32'h7fff_ffff;
    localparam logic [31:0] GEAR_RST = 32'h0000_0001;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [AW-1:0] paddr;
        logic [31:0] pwdata;
    } sms_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } sms_apb_rsp_t;

    typedef struct packed {
        logic [15:0] ctrl_word;
        logic [31:0] fe_window;
        logic [15:0] fe_timeout;
        logic [15:0] trq_pos_lim;
        logic [15:0] trq_neg_lim;
        logic [31:0] range_min;
        logic [31:0] range_max;
        logic [31:0] sw_min;
        logic [31:0] sw_max;
        logic [31:0] gear_num;
        logic [31:0] gear_den;
    } sms_cfg_t;

    typedef struct packed {
        logic [31:0] cmd_pos;
        logic [31:0] act_pos;
        logic [31:0] speed_cmd;
        logic [15:0] torque_act;
        logic [15:0] status_base;
        logic [15:0] status_do2;
        logic [15:0] status_do5;
        logic servo_on;
        logic target_used;
    } sms_fb_t;

endpackage
